// >>> inc/cis_pkg.sv
// Types shared by the charger input supervisor.
package cis_pkg;
	typedef enum logic [2:0] {
		PATH_BATTERY = 3'b001,
		PATH_WALL    = 3'b010,
		PATH_USB     = 3'b100
	} cis_path_type;
endpackage : cis_pkg

// >>> inc/cis_regs.svh
// Named constants of the charger input supervisor.
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH

// Current figures in milliamps, then the precharge divisor, throttle shift and minimum current width.
`define CIS_ILIM_USB_LOW_MA   75
`define CIS_ILIM_USB_HIGH_MA  450
`define CIS_ILIM_WALL_MA      2250
`define CIS_CHG_USB_LOW_MA    75
`define CIS_CHG_USB_STD_MA    450
`define CIS_CHG_USB_HIGH_MA   900
`define CIS_PRECHG_LOW_MA     75
`define CIS_PRECHG_DIVISOR    10
`define CIS_THROTTLE_SHIFT    1
`define CIS_CUR_W_MIN         12

// Comparator bit positions on the synchronised sense bus.
`define CIS_SENSE_W           9
`define CIS_S_ABOVE_UVLO      0
`define CIS_S_ABOVE_RESTART   1
`define CIS_S_ABOVE_6V0       2
`define CIS_S_ABOVE_6V6       3
`define CIS_S_ABOVE_7V0       4
`define CIS_S_USB_VALID       5
`define CIS_S_RAIL_SAG        6
`define CIS_S_OVERLOAD        7
`define CIS_S_USB_LEVEL       8

`endif

// >>> src/cis_charger_input_supervisor.sv
// Input selection, qualification, current limits and input events of the charger.
`timescale 1ns/10ps
`include "cis_regs.svh"

module cis_charger_input_supervisor
	import cis_pkg::*;
#(
	parameter int CUR_W = 12
) (
	input  wire logic             clk_sys,                     // System clock, 200 MHz.
	input  wire logic             reset_n,                     // Async reset, active low.
	input  wire logic             wall_above_uvlo,             // Wall input above 3.5V.
	input  wire logic             wall_above_restart,          // Wall input above 4.0V.
	input  wire logic             wall_above_6v0,              // Wall input above 6.0V.
	input  wire logic             wall_above_6v6,              // Wall input above 6.6V.
	input  wire logic             wall_above_7v0,              // Wall input above 7.0V.
	input  wire logic             usb_source_valid,            // Valid source on USB.
	input  wire logic             system_rail_sag,             // Rail dropped over 200mV.
	input  wire logic             system_overload,             // Demand beyond input.
	input  wire logic             usb_current_level,           // Level pin.
	input  wire logic             otg_switch_on,               // OTG switch is on.
	input  wire logic             ovp_threshold_select,        // 0: 6.6V, 1: 7.0V.
	input  wire logic             usb_high_current_select,     // 1: 900mA USB cap.
	input  wire logic             input_irq_unmask,            // Wall events unmasked.
	input  wire logic             input_connect_irq_enable,    // Wall connect enable.
	input  wire logic             input_disconnect_irq_enable, // Wall disconnect enable.
	input  wire logic             usb_rise_irq_enable,         // USB connect enable.
	input  wire logic             usb_fall_irq_enable,         // USB disconnect enable.
	input  wire logic             usb_irq_unmask,              // USB events unmasked.
	input  wire logic             input_irq_flag_read,         // Read strobe, input flag.
	input  wire logic             usb_irq_flag_read,           // Read strobe, USB flag.
	input  wire logic [CUR_W-1:0] programmed_charge_current,   // Programmed mA.
	output logic                  power_from_wall,             // System on wall input.
	output logic                  power_from_usb,              // System on USB supply.
	output logic                  power_from_battery,          // System on battery.
	output logic                  battery_supplement,          // Battery helps input.
	output logic                  charge_enable,               // Charger may run.
	output logic                  usb_mode,                    // Charging in USB mode.
	output logic                  dynamic_charge_throttle,     // Charge current reduced.
	output logic      [CUR_W-1:0] input_current_limit,         // Input limit, mA.
	output logic      [CUR_W-1:0] charge_current_limit,        // Charge cap, mA.
	output logic      [CUR_W-1:0] precharge_current_limit,     // Precondition cap, mA.
	output logic                  input_valid_level,           // Wall input valid.
	output logic                  usb_valid_level,             // USB source valid.
	output logic                  input_irq_flag,              // Sticky wall event.
	output logic                  usb_irq_flag                 // Sticky USB event.
);
	// ************************************************************
	// Parameter check
	// ************************************************************
	generate
		if (CUR_W < `CIS_CUR_W_MIN) begin : g_bad_cur_w
			$error("CUR_W too narrow for the wall input current limit");
		end
	endgenerate

	function automatic logic [CUR_W-1:0] cur_min(input logic [CUR_W-1:0] a,
						     input logic [CUR_W-1:0] b);
		cur_min = (a < b) ? a : b;
	endfunction : cur_min

	// ************************************************************
	// Synchronisers
	// ************************************************************
	logic [`CIS_SENSE_W-1:0] sense_raw;
	logic [`CIS_SENSE_W-1:0] sense;
	logic [`CIS_SENSE_W-1:0] sense_rise;
	logic [`CIS_SENSE_W-1:0] sense_fall;

	assign sense_raw = {usb_current_level, system_overload, system_rail_sag,
			    usb_source_valid, wall_above_7v0, wall_above_6v6,
			    wall_above_6v0, wall_above_restart, wall_above_uvlo};

	cis_sync_edge #(.WIDTH(`CIS_SENSE_W)) u_sense_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in (sense_raw),
		.level    (sense),
		.rise     (sense_rise),
		.fall     (sense_fall)
	);

	wire s_above_uvlo    = sense[`CIS_S_ABOVE_UVLO];
	wire s_above_restart = sense[`CIS_S_ABOVE_RESTART];
	wire s_above_6v0     = sense[`CIS_S_ABOVE_6V0];
	wire s_above_6v6     = sense[`CIS_S_ABOVE_6V6];
	wire s_above_7v0     = sense[`CIS_S_ABOVE_7V0];
	wire s_rail_sag      = sense[`CIS_S_RAIL_SAG];
	wire s_overload      = sense[`CIS_S_OVERLOAD];
	wire s_usb_level     = sense[`CIS_S_USB_LEVEL];
	wire s_usb_rise      = sense_rise[`CIS_S_USB_VALID];
	wire s_usb_fall      = sense_fall[`CIS_S_USB_VALID];

	// ************************************************************
	// Wall input qualification
	// ************************************************************
	logic uv_lock;
	logic ov_lock;

	// A brief dip under the lockout level must not restart charging until the
	// input has climbed back past the hysteresis point.
	wire ov_trip       = ovp_threshold_select ? s_above_7v0 : s_above_6v6;
	wire next_uv_lock  = !s_above_uvlo ? 1'b1 :
			     (s_above_restart ? 1'b0 : uv_lock);
	wire next_ov_lock  = ov_trip ? 1'b1 : (!s_above_6v0 ? 1'b0 : ov_lock);
	wire next_wall_ok  = !next_uv_lock && !next_ov_lock;
	wire wall_connect  = next_wall_ok && !input_valid_level;
	wire wall_drop     = !next_wall_ok && input_valid_level;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			uv_lock           <= 1'b1;
			ov_lock           <= 1'b0;
			input_valid_level <= 1'b0;
			usb_valid_level   <= 1'b0;
		end else begin
			uv_lock           <= next_uv_lock;
			ov_lock           <= next_ov_lock;
			input_valid_level <= next_wall_ok;
			usb_valid_level   <= sense[`CIS_S_USB_VALID];
		end
	end

	// ************************************************************
	// Path selection
	// ************************************************************
	cis_path_type path;
	cis_path_type next_path;

	// USB fed by our own OTG switch is not a source at all.
	wire usb_ok = usb_valid_level && !otg_switch_on;

	always_comb begin
		if (input_valid_level) begin
			next_path = PATH_WALL;
		end else if (usb_ok) begin
			next_path = PATH_USB;
		end else begin
			next_path = PATH_BATTERY;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			path <= PATH_BATTERY;
		end else begin
			path <= next_path;
		end
	end

	assign power_from_wall    = path[1];
	assign power_from_usb     = path[2];
	assign power_from_battery = path[0];

	// ************************************************************
	// Current limits
	// ************************************************************
	logic [CUR_W-1:0] next_ilim;
	logic [CUR_W-1:0] chg_base;
	logic [CUR_W-1:0] next_pre;

	wire [CUR_W-1:0] programmed_charge_current_tenth = programmed_charge_current / CUR_W'(`CIS_PRECHG_DIVISOR);
	wire [CUR_W-1:0] usb_cap    = usb_high_current_select ? CUR_W'(`CIS_CHG_USB_HIGH_MA)
							      : CUR_W'(`CIS_CHG_USB_STD_MA);
	wire [CUR_W-1:0] next_chg   = s_rail_sag ? (chg_base >> `CIS_THROTTLE_SHIFT)
						 : chg_base;
	wire next_charge  = (input_valid_level || usb_ok) && !ov_lock;

	always_comb begin
		unique case (path)
			PATH_WALL: begin
				next_ilim = CUR_W'(`CIS_ILIM_WALL_MA);
				chg_base  = programmed_charge_current;
				next_pre  = programmed_charge_current_tenth;
			end
			PATH_USB: begin
				if (s_usb_level) begin
					next_ilim = CUR_W'(`CIS_ILIM_USB_HIGH_MA);
					chg_base  = cur_min(usb_cap, programmed_charge_current);
					next_pre  = programmed_charge_current_tenth;
				end else begin
					next_ilim = CUR_W'(`CIS_ILIM_USB_LOW_MA);
					chg_base  = cur_min(CUR_W'(`CIS_CHG_USB_LOW_MA),
							    programmed_charge_current);
					next_pre  = cur_min(CUR_W'(`CIS_PRECHG_LOW_MA),
							    programmed_charge_current_tenth);
				end
			end
			PATH_BATTERY: begin
				next_ilim = '0;
				chg_base  = '0;
				next_pre  = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			input_current_limit     <= '0;
			charge_current_limit    <= '0;
			precharge_current_limit <= '0;
			charge_enable           <= 1'b0;
			usb_mode                <= 1'b0;
			dynamic_charge_throttle <= 1'b0;
			battery_supplement      <= 1'b0;
		end else begin
			input_current_limit     <= next_ilim;
			charge_current_limit    <= next_chg;
			precharge_current_limit <= next_pre;
			charge_enable           <= next_charge;
			usb_mode                <= (path == PATH_USB);
			dynamic_charge_throttle <= s_rail_sag && (path != PATH_BATTERY);
			battery_supplement      <= s_overload && (path != PATH_BATTERY);
		end
	end

	// ************************************************************
	// Event flags
	// ************************************************************
	// A set in the same cycle as a read wins, so no event is ever lost.
	wire input_irq_set = input_irq_unmask &&
			     ((wall_connect && input_connect_irq_enable) ||
			      (wall_drop && input_disconnect_irq_enable));
	wire usb_irq_set   = usb_irq_unmask &&
			     ((s_usb_rise && usb_rise_irq_enable) ||
			      (s_usb_fall && usb_fall_irq_enable));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			input_irq_flag <= 1'b0;
			usb_irq_flag   <= 1'b0;
		end else begin
			input_irq_flag <= input_irq_set ||
					  (input_irq_flag && !input_irq_flag_read);
			usb_irq_flag   <= usb_irq_set ||
					  (usb_irq_flag && !usb_irq_flag_read);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_wall_priority: assert property (input_valid_level |=> path == PATH_WALL)
		else $error("wall input valid but not selected");
	chk_battery_fallback: assert property (
		(!input_valid_level && !usb_valid_level) |=> power_from_battery)
		else $error("no valid input but battery not selected");
	chk_otg_no_charge: assert property (
		(!input_valid_level && otg_switch_on) |=> !power_from_usb ##1 !usb_mode)
		else $error("USB used as source while OTG switch feeds it");
	chk_ovp_trip: assert property (
		ov_trip |=> !input_valid_level ##1 !charge_enable)
		else $error("charging left on above over-voltage threshold");
	chk_ovp_release: assert property (
		(ov_lock && s_above_6v0 && !ov_trip) |=> ov_lock)
		else $error("over-voltage lock released above 6.0V");
	chk_uvlo_restart: assert property (
		(uv_lock && !s_above_restart) |=> !input_valid_level)
		else $error("wall input valid before restart level");
	chk_usb_ilim: assert property (path == PATH_USB |=>
		input_current_limit == ($past(s_usb_level) ? CUR_W'(`CIS_ILIM_USB_HIGH_MA)
							   : CUR_W'(`CIS_ILIM_USB_LOW_MA)))
		else $error("USB input current limit wrong");
	chk_usb_high_cap: assert property (
		(path == PATH_USB && s_usb_level && usb_high_current_select && !s_rail_sag) |=>
		charge_current_limit == cur_min(CUR_W'(`CIS_CHG_USB_HIGH_MA),
						$past(programmed_charge_current)))
		else $error("USB high current cap wrong");
	chk_usb_pre_cap: assert property (
		(path == PATH_USB && !s_usb_level) |=> precharge_current_limit <=
		CUR_W'(`CIS_PRECHG_LOW_MA))
		else $error("USB precondition cap above limit");
	chk_sag_throttle: assert property (
		(s_rail_sag && path == PATH_WALL) |=>
		dynamic_charge_throttle && charge_current_limit ==
		($past(programmed_charge_current) >> `CIS_THROTTLE_SHIFT))
		else $error("charge current not reduced on rail sag");
	chk_wall_connect: assert property (
		($rose(input_valid_level) && $past(input_irq_unmask && input_connect_irq_enable))
		|-> input_irq_flag)
		else $error("wall connect event lost");
	chk_flag_clear: assert property (
		(input_irq_flag_read && !input_irq_set) |=> !input_irq_flag)
		else $error("input flag not cleared by read");
	chk_usb_flag_set: assert property (usb_irq_set |=> usb_irq_flag [*1])
		else $error("USB event did not set flag");
	chk_overload_draw: assert property (
		(s_overload && path != PATH_BATTERY) |=> battery_supplement)
		else $error("battery not allowed to help an overloaded input");
	chk_battery_limit: assert property (
		(path == PATH_BATTERY) |=> input_current_limit == '0 && charge_current_limit == '0)
		else $error("limits left open while running from the battery");
	chk_usb_mode_on: assert property (
		(path == PATH_USB) |=> usb_mode)
		else $error("USB path without USB mode");
	chk_usb_std_cap: assert property (
		(path == PATH_USB && s_usb_level && !usb_high_current_select && !s_rail_sag) |=>
		charge_current_limit == cur_min(CUR_W'(`CIS_CHG_USB_STD_MA),
						$past(programmed_charge_current)))
		else $error("USB standard current cap wrong");
	chk_wall_valid_band: assert property (
		(s_above_uvlo && s_above_restart && !s_above_6v0 && !ov_trip) |=> input_valid_level)
		else $error("wall input inside the band but not valid");
	chk_wall_disconnect: assert property (
		($fell(input_valid_level) && $past(input_irq_unmask && input_disconnect_irq_enable))
		|-> input_irq_flag)
		else $error("wall disconnect event lost");
	chk_usb_rise_irq: assert property (
		(s_usb_rise && usb_rise_irq_enable && usb_irq_unmask) |=> usb_irq_flag)
		else $error("USB connect event lost");
	chk_usb_fall_irq: assert property (
		(s_usb_fall && usb_fall_irq_enable && usb_irq_unmask) |=> usb_irq_flag)
		else $error("USB disconnect event lost");
	chk_usb_flag_masked: assert property (
		(!usb_irq_unmask && !usb_irq_flag) |=> !usb_irq_flag)
		else $error("USB flag set while USB events are masked");
	chk_usb_valid_live: assert property (
		sense[`CIS_S_USB_VALID] |=> usb_valid_level)
		else $error("USB valid level does not follow the source");
	// A level that stays high must not be taken for a second connect, or the
	// host would see a phantom event after every read.
	chk_single_event: assert property (
		sense_rise[`CIS_S_USB_VALID] |=> !sense_rise[`CIS_S_USB_VALID])
		else $error("USB rise event longer than one cycle");
endmodule : cis_charger_input_supervisor

// >>> src/cis_sync_edge.sv
// Two-flop synchroniser bank with edge detection on the stable stage.
`timescale 1ns/10ps
module cis_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,   // System clock.
	input  wire logic             reset_n,   // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] async_in,  // Levels from outside the domain.
	output logic      [WIDTH-1:0] level,     // Synchronised level.
	output logic      [WIDTH-1:0] rise,      // One-cycle pulse on a rising edge.
	output logic      [WIDTH-1:0] fall       // One-cycle pulse on a falling edge.
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stable;
	logic [WIDTH-1:0] prev;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("cis_sync_edge needs WIDTH of at least one");
		end
	endgenerate

	// The meta stage is read only by the stable stage.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta   <= '0;
			stable <= '0;
			prev   <= '0;
		end else begin
			meta   <= async_in;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign level = stable;
	assign rise  = stable & ~prev;
	assign fall  = ~stable & prev;
endmodule : cis_sync_edge

// >>> test/cis_source_model.sv
// Behavioural model of the wall adapter, the USB source and the system load.
`timescale 1ns/10ps
module cis_source_model (
	input  wire logic [15:0] wall_mv,        // Wall input level, millivolts.
	input  wire logic        usb_attached,   // Charging source plugged into USB.
	input  wire logic        otg_active,     // Host has the OTG switch on.
	input  wire logic [15:0] load_ma,        // System demand, milliamps.
	input  wire logic [11:0] limit_ma,       // Input limit granted by the block.
	output logic             above_uvlo,     // Wall above 3.5V.
	output logic             above_restart,  // Wall above 3.5V plus 500mV.
	output logic             above_6v0,      // Wall above 6.0V.
	output logic             above_6v6,      // Wall above 6.6V.
	output logic             above_7v0,      // Wall above 7.0V.
	output logic             usb_valid,      // USB supply valid.
	output logic             rail_sag,       // System rail sagging.
	output logic             overload        // Demand beyond the input.
);
	assign above_uvlo    = wall_mv > 16'h0dac;
	assign above_restart = wall_mv > 16'h0fa0;
	assign above_6v0     = wall_mv > 16'h1770;
	assign above_6v6     = wall_mv > 16'h19c8;
	assign above_7v0     = wall_mv > 16'h1b58;
	// The OTG switch powers the USB supply too, so it looks valid then.
	assign usb_valid     = usb_attached | otg_active;
	// Twice the granted limit is where the rail can no longer be held up.
	assign overload      = load_ma > {4'h0, limit_ma};
	assign rail_sag      = load_ma > {3'h0, limit_ma, 1'b0};
endmodule : cis_source_model

// >>> test/test_charger_input_supervisor.sv
// Self-checking bench for the charger input supervisor.
`timescale 1ns/10ps
module test_charger_input_supervisor;
	logic clk_sys = 1'b0, reset_n = 1'b0, usb_on = 1'b0, otg_on = 1'b0;
	logic lvl = 1'b0, ovp_sel = 1'b0, hc_sel = 1'b0, in_rd = 1'b0, usb_rd = 1'b0;
	logic [15:0] wall_mv = 16'h0000, load_ma = 16'h0000;
	logic [5:0]  irq_en = 6'h00;
	logic [11:0] prog = 12'h3e8, ilim, clim, plim;
	logic a_uvlo, a_rst, a_6v0, a_6v6, a_7v0, usb_ok, sag, ovl;
	logic pw_wall, pw_usb, pw_bat, supp, chg_en, umode, thr;
	logic in_valid, usb_valid, in_flag, usb_flag;
	int   fail_count = 0;
	int   check_count = 0;

	always #2.5 clk_sys = ~clk_sys;

	cis_source_model partner (.wall_mv(wall_mv), .usb_attached(usb_on), .otg_active(otg_on),
		.load_ma(load_ma), .limit_ma(ilim), .above_uvlo(a_uvlo), .above_restart(a_rst),
		.above_6v0(a_6v0), .above_6v6(a_6v6), .above_7v0(a_7v0), .usb_valid(usb_ok),
		.rail_sag(sag), .overload(ovl));

	cis_charger_input_supervisor #(.CUR_W(12)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.wall_above_uvlo(a_uvlo), .wall_above_restart(a_rst), .wall_above_6v0(a_6v0),
		.wall_above_6v6(a_6v6), .wall_above_7v0(a_7v0), .usb_source_valid(usb_ok),
		.system_rail_sag(sag), .system_overload(ovl), .usb_current_level(lvl),
		.otg_switch_on(otg_on), .ovp_threshold_select(ovp_sel),
		.usb_high_current_select(hc_sel), .input_irq_unmask(irq_en[0]),
		.input_connect_irq_enable(irq_en[1]), .input_disconnect_irq_enable(irq_en[2]),
		.usb_rise_irq_enable(irq_en[3]), .usb_fall_irq_enable(irq_en[4]),
		.usb_irq_unmask(irq_en[5]), .input_irq_flag_read(in_rd), .usb_irq_flag_read(usb_rd),
		.programmed_charge_current(prog), .power_from_wall(pw_wall), .power_from_usb(pw_usb),
		.power_from_battery(pw_bat), .battery_supplement(supp), .charge_enable(chg_en),
		.usb_mode(umode), .dynamic_charge_throttle(thr), .input_current_limit(ilim),
		.charge_current_limit(clim), .precharge_current_limit(plim),
		.input_valid_level(in_valid), .usb_valid_level(usb_valid),
		.input_irq_flag(in_flag), .usb_irq_flag(usb_flag));

	// **********************************************************************
	// Shared tasks
	// **********************************************************************
	task check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Waits for the wall-valid level, then long enough for the limits to follow.
	task step(input logic exp_valid);
		int n;
		n = 0;
		while (in_valid !== exp_valid && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (in_valid !== exp_valid) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h timeout on valid", $time, in_valid, exp_valid);
			end_sim();
		end else begin
			repeat (6) @(negedge clk_sys);
			check(12'(in_valid), 12'(exp_valid));
		end
	endtask : step

	// A read returns the flag as it stands and leaves it clear.
	task rd_flag(input logic usb, input logic exp);
		check(12'(usb ? usb_flag : in_flag), 12'(exp));
		if (usb) usb_rd = 1'b1; else in_rd = 1'b1;
		@(negedge clk_sys);
		usb_rd = 1'b0;
		in_rd  = 1'b0;
		@(negedge clk_sys);
		check(12'(usb ? usb_flag : in_flag), 12'h000);
	endtask : rd_flag

	// **********************************************************************
	// Main sequence
	// **********************************************************************
	initial begin
		repeat (4) @(negedge clk_sys);
		check(12'({pw_wall, pw_usb, pw_bat}), 12'h001);
		reset_n = 1'b1;
		irq_en  = 6'h3f;
		usb_on  = 1'b1;
		step(1'b0);
		check(12'({pw_wall, pw_usb, pw_bat, umode, chg_en}), 12'h00b);
		check(12'(usb_valid), 12'h001);
		check(ilim, 12'h04b);
		check(clim, 12'h04b);
		check(plim, 12'h04b);
		rd_flag(1'b1, 1'b1);
		lvl = 1'b1;
		step(1'b0);
		check(ilim, 12'h1c2);
		check(clim, 12'h1c2);
		check(plim, 12'h064);
		hc_sel = 1'b1;
		step(1'b0);
		check(clim, 12'h384);
		prog = 12'h258;
		step(1'b0);
		check(clim, 12'h258);
		check(plim, 12'h03c);
		lvl  = 1'b0;
		prog = 12'h1f4;
		step(1'b0);
		check(clim, 12'h04b);
		check(plim, 12'h032);
		prog = 12'h3e8;
		$display("test usb_limits done");
		otg_on = 1'b1;
		step(1'b0);
		check(12'({pw_usb, chg_en}), 12'h000);
		otg_on = 1'b0;
		step(1'b0);
		rd_flag(1'b1, 1'b0);
		usb_on = 1'b0;
		step(1'b0);
		check(12'({pw_wall, pw_usb, pw_bat}), 12'h001);
		check(12'(usb_valid), 12'h000);
		rd_flag(1'b1, 1'b1);
		irq_en = 6'h1f;
		usb_on = 1'b1;
		step(1'b0);
		rd_flag(1'b1, 1'b0);
		$display("test usb_events done");
		irq_en  = 6'h3f;
		wall_mv = 16'h1388;
		step(1'b1);
		check(12'({pw_wall, pw_usb, pw_bat, umode}), 12'h008);
		check(ilim, 12'h8ca);
		check(clim, 12'h3e8);
		check(plim, 12'h064);
		rd_flag(1'b0, 1'b1);
		load_ma = 16'h0bb8;
		step(1'b1);
		check(12'({supp, thr}), 12'h002);
		load_ma = 16'h1388;
		step(1'b1);
		check(12'(thr), 12'h001);
		check(clim, 12'h1f4);
		load_ma = 16'h0000;
		$display("test wall_path done");
		ovp_sel = 1'b1;
		wall_mv = 16'h1a90;
		step(1'b1);
		check(12'(chg_en), 12'h001);
		wall_mv = 16'h1c20;
		step(1'b0);
		check(12'(chg_en), 12'h000);
		rd_flag(1'b0, 1'b1);
		wall_mv = 16'h1964;
		step(1'b0);
		check(12'(chg_en), 12'h000);
		wall_mv = 16'h157c;
		step(1'b1);
		check(12'(chg_en), 12'h001);
		rd_flag(1'b0, 1'b1);
		ovp_sel = 1'b0;
		wall_mv = 16'h1a90;
		step(1'b0);
		check(12'(chg_en), 12'h000);
		rd_flag(1'b0, 1'b1);
		$display("test over_voltage done");
		usb_on  = 1'b0;
		wall_mv = 16'h1388;
		step(1'b1);
		rd_flag(1'b0, 1'b1);
		wall_mv = 16'h0c80;
		step(1'b0);
		check(12'({pw_bat, chg_en}), 12'h002);
		wall_mv = 16'h0ed8;
		step(1'b0);
		check(12'(chg_en), 12'h000);
		wall_mv = 16'h1068;
		step(1'b1);
		check(12'(chg_en), 12'h001);
		rd_flag(1'b0, 1'b1);
		irq_en  = 6'h3e;
		wall_mv = 16'h0000;
		step(1'b0);
		wall_mv = 16'h1388;
		step(1'b1);
		rd_flag(1'b0, 1'b0);
		$display("test under_voltage done");
		end_sim();
	end
endmodule : test_charger_input_supervisor
